// ### poe_strap_addr_map.sv
// Strap capture, two-wire slave addressing and port mapping of the PoE manager
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "poe_cfg.svh"

// How it works
// - Mode strap level taken once, then frozen
// - Ground gives semi-auto, supply gives auto
// - Two-pair answers prefix, bits 3..1, forced 0/1
// - Address 0 reaches ports 1-4, 1 reaches 5-8
// - Four-pair answers prefix plus all four bits
// - Four-pair map shows only four logical ports
// - Pair strap picks eight 2-pair or four 4-pair
// - No mix of two-pair and four-pair ports
// - Four-pair port drives its two channels together
// - Any two channels may form a port
// - Slave only, fast-plus rates supported
// - Address taken from four address straps
module poe_strap_addr_map (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        mode_strap,
  input  wire logic        pair_strap,
  input  wire logic        address_strap_bit0,
  input  wire logic        address_strap_bit1,
  input  wire logic        address_strap_bit2,
  input  wire logic        address_strap_bit3,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out_o,
  output logic             sda_out_oe_n,
  output logic             auto_mode,
  output logic             four_pair_mode,
  output logic             straps_valid,
  output logic      [7:0]  chan_en
);

  // ----------------------------------------------------------------
  // Input synchronisers and bus edge detection
  // ----------------------------------------------------------------
  logic [7:0] sync1_q, sync2_q;
  logic       scl_d_q, sda_d_q;
  logic       scl_s, sda_s, mode_s, pair_s;
  logic [3:0] addr_s;
  logic       ev_start, ev_stop, ev_rise, ev_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 8'hc3;
      sync2_q <= 8'hc3;
      scl_d_q <= 1'b1;
      sda_d_q <= 1'b1;
    end else begin
      sync1_q <= {scl_in, sda_in, mode_strap, pair_strap,
                  address_strap_bit3, address_strap_bit2, address_strap_bit1, address_strap_bit0};
      sync2_q <= sync1_q;
      scl_d_q <= sync2_q[7];
      sda_d_q <= sync2_q[6];
    end
  end

  assign scl_s    = sync2_q[7];
  assign sda_s    = sync2_q[6];
  assign mode_s   = sync2_q[5];
  assign pair_s   = sync2_q[4];
  assign addr_s   = sync2_q[3:0];
  assign ev_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
  assign ev_stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;
  assign ev_rise  = scl_s & ~scl_d_q;
  assign ev_fall  = ~scl_s & scl_d_q;

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  poe_pkg::strap_t strap_q, strap_d;
  logic [1:0]      settle_q, settle_d;
  logic            strap_done_q, strap_done_d;

  always_comb begin
    strap_d      = strap_q;
    settle_d     = settle_q;
    strap_done_d = strap_done_q;
    if (!strap_done_q) begin
      settle_d = settle_q + 2'd1;
      // Sampled once after reset, never again while running
      if (settle_q == `STRAP_SETTLE) begin
        strap_done_d        = 1'b1;
        strap_d.auto_mode   = mode_s;
        strap_d.four_pair   = pair_s;
        strap_d.addr        = addr_s;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q      <= '0;
      settle_q     <= 2'd0;
      strap_done_q <= 1'b0;
    end else begin
      strap_q      <= strap_d;
      settle_q     <= settle_d;
      strap_done_q <= strap_done_d;
    end
  end

  // ----------------------------------------------------------------
  // Two-wire slave
  // ----------------------------------------------------------------
  poe_pkg::i2c_st_t st_q, st_d;
  logic [3:0]       cnt_q, cnt_d;
  logic [7:0]       sh_q, sh_d, ptr_q, ptr_d, rd_byte, wr_val;
  logic             win_q, win_d, rw_q, rw_d, oe_n_q, oe_n_d;
  logic             hit2, hit4, hit, wr_en, ptr_ok;
  logic [2:0]       idx;
  logic [7:0]       port_ctrl_q [8];
  logic [7:0]       port_ctrl_d [8];

  // Forced low bit selects the four-port portion in two-pair mode
  assign hit2    = sh_q[7:1] == {`ADDR_PREFIX, strap_q.addr[3:1], sh_q[1]};
  assign hit4    = sh_q[7:1] == {`ADDR_PREFIX, strap_q.addr};
  assign hit     = strap_done_q & (strap_q.four_pair ? hit4 : hit2);
  assign ptr_ok  = ptr_q[7:2] == 6'h00;
  assign idx     = {win_q, ptr_q[1:0]};
  assign rd_byte = ptr_ok ? port_ctrl_q[idx] : 8'h00;
  assign wr_val  = sh_q;

  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    ptr_d  = ptr_q;
    win_d  = win_q;
    rw_d   = rw_q;
    oe_n_d = oe_n_q;
    wr_en  = 1'b0;
    if (ev_stop) begin
      st_d   = poe_pkg::st_idle;
      oe_n_d = 1'b1;
    end else if (ev_start) begin
      st_d   = poe_pkg::st_addr;
      cnt_d  = 4'd0;
      oe_n_d = 1'b1;
    end else if (ev_rise) begin
      case (st_q)
        poe_pkg::st_addr, poe_pkg::st_ptr, poe_pkg::st_wdat: begin
          sh_d  = {sh_q[6:0], sda_s};
          cnt_d = cnt_q + 4'd1;
        end
        poe_pkg::st_rack: begin
          if (sda_s) begin
            st_d = poe_pkg::st_idle;
          end
        end
        default: begin
        end
      endcase
    end else if (ev_fall) begin
      case (st_q)
        poe_pkg::st_addr: begin
          if (cnt_q == `BYTE_BITS) begin
            if (hit) begin
              st_d   = poe_pkg::st_aack;
              oe_n_d = 1'b0;
              win_d  = ~strap_q.four_pair & sh_q[1];
              rw_d   = sh_q[0];
            end else begin
              st_d = poe_pkg::st_idle;
            end
          end
        end
        poe_pkg::st_aack: begin
          if (rw_q) begin
            st_d   = poe_pkg::st_rdat;
            sh_d   = rd_byte;
            oe_n_d = rd_byte[7];
            cnt_d  = 4'd1;
          end else begin
            st_d   = poe_pkg::st_ptr;
            oe_n_d = 1'b1;
            cnt_d  = 4'd0;
          end
        end
        poe_pkg::st_ptr: begin
          if (cnt_q == `BYTE_BITS) begin
            ptr_d  = sh_q;
            st_d   = poe_pkg::st_pack;
            oe_n_d = 1'b0;
          end
        end
        poe_pkg::st_wdat: begin
          if (cnt_q == `BYTE_BITS) begin
            wr_en  = ptr_ok;
            st_d   = poe_pkg::st_wack;
            oe_n_d = 1'b0;
          end
        end
        poe_pkg::st_pack, poe_pkg::st_wack: begin
          if (st_q == poe_pkg::st_wack) begin
            ptr_d = ptr_q + 8'd1;
          end
          st_d   = poe_pkg::st_wdat;
          oe_n_d = 1'b1;
          cnt_d  = 4'd0;
        end
        poe_pkg::st_rdat: begin
          if (cnt_q == `BYTE_BITS) begin
            st_d   = poe_pkg::st_rack;
            oe_n_d = 1'b1;
            ptr_d  = ptr_q + 8'd1;
          end else begin
            sh_d   = {sh_q[6:0], 1'b0};
            oe_n_d = sh_q[6];
            cnt_d  = cnt_q + 4'd1;
          end
        end
        poe_pkg::st_rack: begin
          st_d   = poe_pkg::st_rdat;
          sh_d   = rd_byte;
          oe_n_d = rd_byte[7];
          cnt_d  = 4'd1;
        end
        default: begin
          st_d = poe_pkg::st_idle;
        end
      endcase
    end
  end

  always_comb begin
    for (int i = 0; i < 8; i++) begin
      port_ctrl_d[i] = port_ctrl_q[i];
      if (wr_en && idx == 3'(i)) begin
        port_ctrl_d[i] = wr_val;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= poe_pkg::st_idle;
      cnt_q  <= 4'd0;
      sh_q   <= 8'h00;
      ptr_q  <= 8'h00;
      win_q  <= 1'b0;
      rw_q   <= 1'b0;
      oe_n_q <= 1'b1;
      for (int i = 0; i < 8; i++) begin
        port_ctrl_q[i] <= `PORT_RESET;
      end
    end else begin
      st_q   <= st_d;
      cnt_q  <= cnt_d;
      sh_q   <= sh_d;
      ptr_q  <= ptr_d;
      win_q  <= win_d;
      rw_q   <= rw_d;
      oe_n_q <= oe_n_d;
      for (int i = 0; i < 8; i++) begin
        port_ctrl_q[i] <= port_ctrl_d[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel enables and APB slave
  // ----------------------------------------------------------------
  logic [23:0] pair_q, pair_d;
  logic [7:0]  chan_q, chan_d, two_vec, four_vec;
  logic [31:0] prdata_q, prdata_d;
  logic        pready_q, pready_d, pslverr_q, pslverr_d, setup, mapped;

  // A logical port switches both of its paired channels, which may be any two
  always_comb begin
    for (int c = 0; c < 8; c++) begin
      two_vec[c]  = port_ctrl_q[c][0];
      four_vec[c] = 1'b0;
      for (int p = 0; p < 4; p++) begin
        four_vec[c] = four_vec[c] | (port_ctrl_q[p][0] &
                      ((pair_q[6*p+:3] == 3'(c)) | (pair_q[6*p+3+:3] == 3'(c))));
      end
    end
    chan_d = strap_q.four_pair ? four_vec : two_vec;
  end

  assign setup  = psel & ~penable;
  assign mapped = paddr == `OFF_STATUS || paddr == `OFF_PAIR || paddr == `OFF_CHAN ||
                  paddr == `OFF_PORT_LO || paddr == `OFF_PORT_HI;

  always_comb begin
    pair_d    = pair_q;
    pready_d  = setup;
    pslverr_d = setup & (~mapped | (pwrite & paddr != `OFF_PAIR));
    prdata_d  = 32'h00000000;
    if (psel && penable && pready_q && pwrite && paddr == `OFF_PAIR) begin
      pair_d = pwdata[23:0];
    end
    if (setup && !pwrite) begin
      case (paddr)
        `OFF_STATUS:  prdata_d = {24'h000000, st_q != poe_pkg::st_idle, strap_done_q, strap_q};
        `OFF_PAIR:    prdata_d = {8'h00, pair_q};
        `OFF_CHAN:    prdata_d = {24'h000000, chan_q};
        `OFF_PORT_LO: prdata_d = {port_ctrl_q[3], port_ctrl_q[2], port_ctrl_q[1], port_ctrl_q[0]};
        `OFF_PORT_HI: prdata_d = {port_ctrl_q[7], port_ctrl_q[6], port_ctrl_q[5], port_ctrl_q[4]};
        default:      prdata_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pair_q    <= `PAIR_RESET;
      chan_q    <= 8'h00;
      prdata_q  <= 32'h00000000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pair_q    <= pair_d;
      chan_q    <= chan_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  assign prdata         = prdata_q;
  assign pready         = pready_q;
  assign pslverr        = pslverr_q;
  assign sda_out_o      = 1'b0 & oe_n_q;
  assign sda_out_oe_n   = oe_n_q;
  assign auto_mode      = strap_q.auto_mode;
  assign four_pair_mode = strap_q.four_pair;
  assign straps_valid   = strap_done_q;
  assign chan_en        = chan_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_addr_done;
    ev_fall && st_q == poe_pkg::st_addr && cnt_q == `BYTE_BITS;
  endsequence
  sequence s_apb_setup;
    psel && !penable;
  endsequence

  AST_STRAP_FROZEN:
    assert property (strap_done_q && $past(strap_done_q) |-> $stable(strap_q)) else $error("strap moved");
  AST_AUTO_LEVEL:
    assert property ($rose(strap_done_q) |-> strap_q.auto_mode == $past(mode_s)) else $error("mode level");
  AST_PAIR_LEVEL:
    assert property ($rose(strap_done_q) |-> strap_q.four_pair == $past(pair_s)) else $error("pair level");
  AST_ADDR_LEVEL:
    assert property ($rose(strap_done_q) |-> strap_q.addr == $past(addr_s)) else $error("addr straps");
  AST_NO_ACK:
    assert property (s_addr_done ##0 !hit |=> st_q == poe_pkg::st_idle && oe_n_q) else $error("acked stray");
  AST_ACK_TWO:
    assert property (s_addr_done ##0 (strap_done_q && !strap_q.four_pair && hit2) |=>
      st_q == poe_pkg::st_aack && !oe_n_q && win_q == $past(sh_q[1])) else $error("two-pair ack");
  AST_ACK_FOUR:
    assert property (s_addr_done ##0 (strap_done_q && strap_q.four_pair && hit4) |=>
      st_q == poe_pkg::st_aack && !oe_n_q && !win_q) else $error("four-pair ack");
  AST_TWO_CHAN:
    assert property (!strap_q.four_pair && $stable(strap_q) |-> chan_q == $past(two_vec)) else $error("two chan");
  AST_FOUR_CHAN:
    assert property (strap_q.four_pair && $past(strap_q.four_pair) && $past(port_ctrl_q[0][0]) && $stable(pair_q)
      |-> chan_q[pair_q[2:0]] && chan_q[pair_q[5:3]]) else $error("pair chan");
  AST_APB_READY:
    assert property (s_apb_setup |=> pready_q ##1 !pready_q) else $error("apb ready");
  AST_STOP_IDLE:
    assert property (ev_stop |=> st_q == poe_pkg::st_idle && oe_n_q) else $error("stop");

endmodule
`default_nettype wire

// ### poe_cfg.svh
// Constants for the strap capture, slave address and register map of the PoE manager
`ifndef POE_CFG_SVH
`define POE_CFG_SVH

// Fixed upper bits of the seven-bit slave address
`define ADDR_PREFIX   3'b010
// Bits per bus byte
`define BYTE_BITS     4'd8
// Clocks after reset release before the synchronised straps are taken
`define STRAP_SETTLE  2'd2

// Register byte offsets
`define OFF_STATUS    12'h000
`define OFF_PAIR      12'h004
`define OFF_CHAN      12'h008
`define OFF_PORT_LO   12'h00c
`define OFF_PORT_HI   12'h010

// Pairing reset: logical port p uses channels 2p and 2p+1
`define PAIR_RESET    24'hfac688
`define PORT_RESET    8'h00

`endif

// ### poe_pkg.sv
// Types shared by the PoE manager strap and address logic
package poe_pkg;

  typedef struct packed {
    logic       auto_mode;
    logic       four_pair;
    logic [3:0] addr;
  } strap_t;

  typedef enum logic [3:0] {
    st_idle,
    st_addr,
    st_aack,
    st_ptr,
    st_pack,
    st_wdat,
    st_wack,
    st_rdat,
    st_rack
  } i2c_st_t;

endpackage

// ### i2c_host_model.sv
// Two-wire bus host model: drives clock and data-in, reads data-out
`timescale 1ns/1ps
`default_nettype none
module i2c_host_model (
  input  wire logic pclk,
  input  wire logic sda_line,
  output var  logic scl_in,
  output var  logic sda_in
);
  // ----------------------------------------
  // Bit timing
  // ----------------------------------------
  // Quarter of a 1 MHz bit at 125 MHz
  localparam int QTR = 31;

  initial begin
    scl_in = 1'b1;
    sda_in = 1'b1;
  end

  // ----------------------------------------
  // Bus conditions and bytes
  // ----------------------------------------
  // Works from idle and as a repeated start
  task automatic send_start();
    sda_in <= 1'b1;
    repeat (QTR) @(posedge pclk);
    scl_in <= 1'b1;
    repeat (QTR) @(posedge pclk);
    sda_in <= 1'b0;
    repeat (QTR) @(posedge pclk);
    scl_in <= 1'b0;
    repeat (QTR) @(posedge pclk);
  endtask

  task automatic send_stop();
    sda_in <= 1'b0;
    repeat (QTR) @(posedge pclk);
    scl_in <= 1'b1;
    repeat (QTR) @(posedge pclk);
    sda_in <= 1'b1;
    repeat (QTR) @(posedge pclk);
  endtask

  // Data-out is seen through its pull-up, so a released line reads high
  task automatic bit_io(input logic b, output logic r);
    sda_in <= b;
    repeat (QTR) @(posedge pclk);
    scl_in <= 1'b1;
    repeat (QTR) @(posedge pclk);
    r = sda_line;
    repeat (QTR) @(posedge pclk);
    scl_in <= 1'b0;
    repeat (QTR) @(posedge pclk);
  endtask

  task automatic write_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = ~r;
  endtask

  // Releases data-in for eight bits, then sends the ack bit given
  task automatic read_byte(input logic nack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for strap capture, slave addressing and port mapping
`timescale 1ns/1ps
`default_nettype none
`include "poe_cfg.svh"
module tb_top;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        mode_strap, pair_strap, scl_in, sda_in, sda_out_o, sda_out_oe_n;
  logic        address_strap_bit0, address_strap_bit1, address_strap_bit2, address_strap_bit3;
  logic        auto_mode, four_pair_mode, straps_valid, err, ack;
  logic [7:0]  chan_en;
  wire  logic  sda_line;
  int          n_fail, n_compared;
  // Logical port p -> channels a,b: 0->0,6 1->2,3 2->4,5 3->1,7
  localparam logic [23:0] NEW_PAIR = {3'd7, 3'd1, 3'd5, 3'd4, 3'd3, 3'd2, 3'd6, 3'd0};

  // ----------------------------------------
  // Block, host and clock
  // ----------------------------------------
  assign sda_line = sda_out_oe_n ? 1'b1 : sda_out_o;
  poe_strap_addr_map dut_u (
    .pclk               (pclk),
    .presetn            (presetn),
    .psel               (psel),
    .penable            (penable),
    .pwrite             (pwrite),
    .paddr              (paddr),
    .pwdata             (pwdata),
    .prdata             (prdata),
    .pready             (pready),
    .pslverr            (pslverr),
    .mode_strap         (mode_strap),
    .pair_strap         (pair_strap),
    .address_strap_bit0 (address_strap_bit0),
    .address_strap_bit1 (address_strap_bit1),
    .address_strap_bit2 (address_strap_bit2),
    .address_strap_bit3 (address_strap_bit3),
    .scl_in             (scl_in),
    .sda_in             (sda_in),
    .sda_out_o          (sda_out_o),
    .sda_out_oe_n       (sda_out_oe_n),
    .auto_mode          (auto_mode),
    .four_pair_mode     (four_pair_mode),
    .straps_valid       (straps_valid),
    .chan_en            (chan_en)
  );
  i2c_host_model host_u (
    .pclk     (pclk),
    .sda_line (sda_line),
    .scl_in   (scl_in),
    .sda_in   (sda_in)
  );

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      stop_test();
    end
  endtask

  task automatic reg_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(what, rd, exp);
  endtask

  task automatic do_reset(input logic m, input logic p, input logic [3:0] a);
    int n;
    presetn <= 1'b0;
    mode_strap <= m;
    pair_strap <= p;
    {address_strap_bit3, address_strap_bit2, address_strap_bit1, address_strap_bit0} <= a;
    repeat (10) @(posedge pclk);
    chk("oe_n in reset", {31'h0, sda_out_oe_n}, 32'h1);
    chk("chan_en in reset", {24'h0, chan_en}, 32'h0);
    chk("sda_out_o level", {31'h0, sda_out_o}, 32'h0);
    presetn <= 1'b1;
    n = 0;
    while (straps_valid !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    if (straps_valid !== 1'b1) begin
      n_fail++;
      stop_test();
    end
    chk("auto_mode", {31'h0, auto_mode}, {31'h0, m});
    chk("four_pair_mode", {31'h0, four_pair_mode}, {31'h0, p});
  endtask

  // Pointer 0, then five data bytes, first byte in the top bits
  task automatic i2c_wr(input logic [6:0] a, input logic [39:0] d);
    logic k;
    host_u.send_start();
    host_u.write_byte({a, 1'b0}, ack);
    if (ack === 1'b1) begin
      host_u.write_byte(8'h00, k);
      for (int i = 4; i >= 0; i--) begin
        host_u.write_byte(d[8*i +: 8], k);
      end
    end
    host_u.send_stop();
  endtask

  // Pointer 0, repeated start, then one byte read back with a final nack
  task automatic i2c_rd(input logic [6:0] a, output logic [7:0] d);
    logic k;
    d = 8'h00;
    host_u.send_start();
    host_u.write_byte({a, 1'b0}, ack);
    host_u.write_byte(8'h00, k);
    host_u.send_start();
    host_u.write_byte({a, 1'b1}, ack);
    if (ack === 1'b1) begin
      host_u.read_byte(1'b1, d);
    end
    host_u.send_stop();
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_two_pair();
    do_reset(1'b0, 1'b0, 4'ha);
    mode_strap <= 1'b1;
    repeat (10) @(posedge pclk);
    chk("mode frozen", {31'h0, auto_mode}, 32'h0);
    reg_chk("status", `OFF_STATUS, 32'h0000_004a);
    reg_chk("pair reset", `OFF_PAIR, {8'h00, `PAIR_RESET});
    apb(1'b1, `OFF_STATUS, 32'hffff_ffff);
    chk("ro write err", {31'h0, err}, 32'h1);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("unmapped err", {31'h0, err}, 32'h1);
    i2c_wr(7'b0101010, 40'h01_0000_0000);
    chk("ack low window", {31'h0, ack}, 32'h1);
    i2c_wr(7'b0101011, 40'h01_0000_0000);
    chk("ack high window", {31'h0, ack}, 32'h1);
    i2c_wr(7'b0100010, 40'h01_0101_0101);
    chk("foreign address", {31'h0, ack}, 32'h0);
    chk("chan_en two-pair", {24'h0, chan_en}, 32'h11);
    reg_chk("port hi", `OFF_PORT_HI, 32'h0000_0001);
    $display("test two_pair done");
  endtask

  task automatic t_four_pair();
    logic [7:0] rb;
    do_reset(1'b1, 1'b1, 4'h5);
    reg_chk("status", `OFF_STATUS, 32'h0000_0075);
    i2c_wr(7'b0100100, 40'h01_0101_0101);
    chk("other lsb", {31'h0, ack}, 32'h0);
    apb(1'b1, `OFF_PAIR, {8'h00, NEW_PAIR});
    reg_chk("pair", `OFF_PAIR, {8'h00, NEW_PAIR});
    i2c_wr(7'b0100101, 40'h01_0000_0101);
    chk("ack four-pair", {31'h0, ack}, 32'h1);
    chk("chan_en four-pair", {24'h0, chan_en}, 32'hc3);
    reg_chk("port lo", `OFF_PORT_LO, 32'h0100_0001);
    reg_chk("port hi", `OFF_PORT_HI, 32'h0000_0000);
    reg_chk("chan", `OFF_CHAN, 32'h0000_00c3);
    i2c_rd(7'b0100101, rb);
    chk("read ack", {31'h0, ack}, 32'h1);
    chk("read port0", {24'h0, rb}, 32'h01);
    $display("test four_pair done");
  endtask

  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    {mode_strap, pair_strap} = 2'b00;
    {address_strap_bit3, address_strap_bit2, address_strap_bit1, address_strap_bit0} = 4'h0;
    n_fail = 0;
    n_compared = 0;
    t_two_pair();
    t_four_pair();
    stop_test();
  end
endmodule
`default_nettype wire
